// ---- include/swa_pkg.sv ----
// Notes on behaviour
// - decode opcode, function, and register specifiers
// - bits 10..6 must be zero; a non-zero field is flagged on BAD_ZERO_FIELD but still executes
// - add second source word to first
// - overflow: no write, raise overflow exception
// - no overflow: write sum to destination
// - unsigned variant always writes, never traps
package swa_pkg;

	// ==========================================================
	// instruction field layout
	localparam int OPC_HI = 31;
	localparam int OPC_LO = 26;
	localparam int SRC1_HI = 25;
	localparam int SRC1_LO = 21;
	localparam int SRC2_HI = 20;
	localparam int SRC2_LO = 16;
	localparam int DST_HI = 15;
	localparam int DST_LO = 11;
	localparam int ZF_HI = 10;
	localparam int ZF_LO = 6;
	localparam int FN_HI = 5;
	localparam int FN_LO = 0;
	localparam int WORD_W = 32;
	localparam int SIGN_BIT = 31;
	localparam int CARRY_BIT = 32;

	// ==========================================================
	// encodings
	localparam logic [5:0] OPC_ZERO_MAJOR = 6'h00;
	localparam logic [5:0] FN_ADD_TRAP = 6'h20;
	localparam logic [5:0] FN_ADD_NO_TRAP = 6'h21;
	localparam logic [4:0] ZERO_FIELD = 5'h00;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
	localparam logic [4:0] REG_ZERO = 5'h00;

	// decoded instruction
	typedef struct packed {
		logic       hit;
		logic       trap_en;
		logic       zero_ok;
		logic [4:0] first_source_specifier;
		logic [4:0] second_source_specifier;
		logic [4:0] dst;
	} swa_dec_t;

	// write-back and exception result
	typedef struct packed {
		logic        wr_en;
		logic [4:0]  wr_addr;
		logic [31:0] wr_data;
		logic        ovf_exc;
		logic        bad_zero;
	} swa_res_t;

endpackage : swa_pkg

// ---- hdl/swa_decode.sv ----
`timescale 1ns/1ps
// ==========================================================
// instruction decoder, purely combinational
module swa_decode
	import swa_pkg::*;
(
	// instruction in
	input  wire logic [31:0] instr,
	// decoded fields out
	output swa_dec_t         dec
);

	// match opcode group and function code, split out specifiers
	always_comb
	begin
		dec.hit = (instr[OPC_HI:OPC_LO] == OPC_ZERO_MAJOR) &&
			((instr[FN_HI:FN_LO] == FN_ADD_TRAP) ||
			 (instr[FN_HI:FN_LO] == FN_ADD_NO_TRAP));
		dec.trap_en = (instr[FN_HI:FN_LO] == FN_ADD_TRAP);
		dec.zero_ok = (instr[ZF_HI:ZF_LO] == ZERO_FIELD);
		dec.first_source_specifier = instr[SRC1_HI:SRC1_LO];
		dec.second_source_specifier = instr[SRC2_HI:SRC2_LO];
		dec.dst = instr[DST_HI:DST_LO];
	end

endmodule : swa_decode

// ---- hdl/swa_top.sv ----
`timescale 1ns/1ps
// ==========================================================
// signed word add with overflow trap, one-cycle registered datapath
module swa_top
	import swa_pkg::*;
(
	// clock and reset
	input  wire logic        CLK_SYS,
	input  wire logic        RESET,
	input  wire logic        CE,
	// issue side
	input  wire logic        ISSUE_VALID,
	input  wire logic [31:0] INSTR,
	// operands read from the general_register_file
	input  wire logic [31:0] SRC1_DATA,
	input  wire logic [31:0] SRC2_DATA,
	// read specifiers toward the general_register_file
	output logic      [4:0]  SRC1_ADDR,
	output logic      [4:0]  SRC2_ADDR,
	// write-back toward the general_register_file
	output logic             WR_EN,
	output logic      [4:0]  WR_ADDR,
	output logic      [31:0] WR_DATA,
	// exception logic
	output logic             OVF_EXC,
	output logic             BAD_ZERO_FIELD,
	output logic             DONE
);

	// ==========================================================
	// decode
	swa_dec_t dec;
	logic     [32:0] sum33;
	logic            ovf;
	logic            go;
	swa_res_t        res_r;
	swa_res_t        res_nxt;
	logic            done_r;
	logic            done_nxt;

	swa_decode u_dec
	(
		.instr (INSTR),
		.dec   (dec)
	);

	// operand read addresses come straight from the decoder
	assign SRC1_ADDR = dec.first_source_specifier;
	assign SRC2_ADDR = dec.second_source_specifier;

	// ==========================================================
	// arithmetic: sign-extend both to 33 bits, overflow when top two differ
	assign sum33 = {SRC1_DATA[SIGN_BIT], SRC1_DATA} +
		{SRC2_DATA[SIGN_BIT], SRC2_DATA};
	assign ovf = sum33[CARRY_BIT] != sum33[SIGN_BIT];
	assign go = ISSUE_VALID && dec.hit;

	// next result; a non-zero reserved field is flagged but still executes,
	// since the outcome is unpredictable anyway and flagging costs nothing
	always_comb
	begin
		res_nxt = '0;
		done_nxt = go;
		if (go)
		begin
			res_nxt.wr_addr = dec.dst;
			res_nxt.wr_data = sum33[SIGN_BIT:0];
			res_nxt.bad_zero = !dec.zero_ok;
			if (dec.trap_en && ovf)
			begin
				res_nxt.wr_en = 1'b0;
				res_nxt.ovf_exc = 1'b1;
				res_nxt.wr_data = WORD_ZERO;
			end
			else
			begin
				res_nxt.wr_en = 1'b1;
			end
		end
	end

	// registers; clock enable low freezes everything except reset, which clears them regardless of CE
	always_ff @(posedge CLK_SYS)
	begin
		if (RESET)
		begin
			res_r <= '0;
			done_r <= 1'b0;
		end
		else if (CE)
		begin
			res_r <= res_nxt;
			done_r <= done_nxt;
		end
	end

	assign WR_EN = res_r.wr_en;
	assign WR_ADDR = res_r.wr_addr;
	assign WR_DATA = res_r.wr_data;
	assign OVF_EXC = res_r.ovf_exc;
	assign BAD_ZERO_FIELD = res_r.bad_zero;
	assign DONE = done_r;

	// ==========================================================
	// checks
	// every check below is clock-enable aware: with CE low the result
	// registers hold, so antecedents name CE wherever a new result is implied
	property p_trap_no_write;
		@(posedge CLK_SYS) disable iff (RESET)
		(CE && go && dec.trap_en && ovf) |=> (OVF_EXC && !WR_EN);
	endproperty
	a_trap_no_write: assert property (p_trap_no_write)
		else $error("overflow did not suppress write");

	property p_write_sum;
		@(posedge CLK_SYS) disable iff (RESET)
		(CE && go && !(dec.trap_en && ovf)) |=>
			(WR_EN && WR_DATA == $past(SRC1_DATA) + $past(SRC2_DATA));
	endproperty
	a_write_sum: assert property (p_write_sum)
		else $error("sum not written");

	property p_dst;
		@(posedge CLK_SYS) disable iff (RESET)
		(CE && go) |=> (WR_ADDR == $past(INSTR[DST_HI:DST_LO]) || OVF_EXC);
	endproperty
	a_dst: assert property (p_dst)
		else $error("wrong destination");

	property p_no_trap_variant;
		@(posedge CLK_SYS) disable iff (RESET)
		(CE && go && !dec.trap_en) |=> (!OVF_EXC && WR_EN);
	endproperty
	a_no_trap_variant: assert property (p_no_trap_variant)
		else $error("non-trapping add trapped");

	property p_exc_cause;
		@(posedge CLK_SYS) disable iff (RESET)
		$rose(OVF_EXC) |-> $past(CE && go && dec.trap_en && ovf);
	endproperty
	a_exc_cause: assert property (p_exc_cause)
		else $error("spurious overflow");

	property p_zero_flag;
		@(posedge CLK_SYS) disable iff (RESET)
		(CE && go) |=> (BAD_ZERO_FIELD == ($past(INSTR[ZF_HI:ZF_LO]) != ZERO_FIELD));
	endproperty
	a_zero_flag: assert property (p_zero_flag)
		else $error("reserved field flag wrong");

	property p_overflow_sign;
		@(posedge CLK_SYS) disable iff (RESET)
		(CE && go && dec.trap_en &&
			SRC1_DATA[SIGN_BIT] != SRC2_DATA[SIGN_BIT]) |=> !OVF_EXC;
	endproperty
	a_overflow_sign: assert property (p_overflow_sign)
		else $error("mixed signs cannot overflow");

	property p_no_op_idle;
		@(posedge CLK_SYS) disable iff (RESET)
		(CE && !go) |=> (!WR_EN && !OVF_EXC && !DONE);
	endproperty
	a_no_op_idle: assert property (p_no_op_idle)
		else $error("activity without decoded add");

	property p_freeze;
		@(posedge CLK_SYS) disable iff (RESET)
		!CE |=> $stable(WR_DATA) && $stable(WR_EN);
	endproperty
	a_freeze: assert property (p_freeze)
		else $error("state moved with clock enable low");

	// read specifiers are pure wiring from the instruction word
	property p_src_addr;
		@(posedge CLK_SYS) disable iff (RESET)
		(SRC1_ADDR == INSTR[SRC1_HI:SRC1_LO]) && (SRC2_ADDR == INSTR[SRC2_HI:SRC2_LO]);
	endproperty
	a_src_addr: assert property (p_src_addr)
		else $error("read specifier not taken from instruction");

	// an exception never travels with a write or a stale sum
	property p_exc_excl;
		@(posedge CLK_SYS) disable iff (RESET)
		OVF_EXC |-> (!WR_EN && WR_DATA == WORD_ZERO && DONE);
	endproperty
	a_exc_excl: assert property (p_exc_excl)
		else $error("exception and write together");

	// a trapping add that stays in range must write and not trap
	property p_trap_in_range;
		@(posedge CLK_SYS) disable iff (RESET)
		(CE && go && dec.trap_en && !ovf) |=> (WR_EN && !OVF_EXC);
	endproperty
	a_trap_in_range: assert property (p_trap_in_range)
		else $error("in-range trapping add did not write");

	// the non-trapping variant keeps the wrapped sum even on overflow
	property p_notrap_wrap;
		@(posedge CLK_SYS) disable iff (RESET)
		(CE && go && !dec.trap_en && ovf) |=>
			(WR_EN && WR_DATA == $past(SRC1_DATA) + $past(SRC2_DATA));
	endproperty
	a_notrap_wrap: assert property (p_notrap_wrap)
		else $error("wrapped sum lost on non-trapping add");

	// completion flag moves in step with exactly one kind of result
	property p_done_pair;
		@(posedge CLK_SYS) disable iff (RESET)
		DONE == (WR_EN || OVF_EXC);
	endproperty
	a_done_pair: assert property (p_done_pair)
		else $error("completion flag out of step with result");

	// reset must not leave a write or exception pending for the register file
	property p_reset_clear;
		@(posedge CLK_SYS)
		RESET |=> (!WR_EN && !OVF_EXC && !DONE && !BAD_ZERO_FIELD);
	endproperty
	a_reset_clear: assert property (p_reset_clear)
		else $error("reset left a result flag set");

	c_trap: cover property (@(posedge CLK_SYS) disable iff (RESET) OVF_EXC);
	c_write: cover property (@(posedge CLK_SYS) disable iff (RESET) WR_EN);
	c_notrap_ovf: cover property (@(posedge CLK_SYS) disable iff (RESET)
		CE && go && !dec.trap_en && ovf);
	c_bad_zero: cover property (@(posedge CLK_SYS) disable iff (RESET) BAD_ZERO_FIELD);
	c_freeze: cover property (@(posedge CLK_SYS) disable iff (RESET)
		!CE && WR_EN);

endmodule : swa_top

// ---- verification/swa_rf_model.sv ----
`timescale 1ns/1ps
// ==========================================================
// general register file model: two read ports, one write port
module swa_rf_model
	import swa_pkg::*;
(
	// clock
	input  wire logic        clk,
	// read ports
	input  wire logic [4:0]  rd1_addr,
	input  wire logic [4:0]  rd2_addr,
	output logic      [31:0] rd1_data,
	output logic      [31:0] rd2_data,
	// write port
	input  wire logic        wr_en,
	input  wire logic [4:0]  wr_addr,
	input  wire logic [31:0] wr_data
);
	logic [31:0] regs_r [32];
	// register 0 always reads zero; plain always so the bench may preload
	assign rd1_data = (rd1_addr == REG_ZERO) ? WORD_ZERO : regs_r[rd1_addr];
	assign rd2_data = (rd2_addr == REG_ZERO) ? WORD_ZERO : regs_r[rd2_addr];
	// writes land on the edge after the core raises its write strobe
	always @(posedge clk)
		if (wr_en === 1'b1) regs_r[wr_addr] <= wr_data;
endmodule : swa_rf_model

// ---- verification/tb.sv ----
`timescale 1ns/1ps
// ==========================================================
// bench: corner sums, then random words
module tb
	import swa_pkg::*;
;
	logic clk = 1'b0, rst = 1'b1, vld = 1'b0, ce = 1'b1;
	logic [31:0] ins = '0, d1, d2, wd, rw, e_wd;
	logic [4:0] a1, a2, wa;
	logic we, ovf, bad, done, e_we, e_ovf, e_done;
	int errors = 0, total_checks = 0, seed = 32'h2b61a2ca, i;
	always #5 clk = ~clk;
	// clock enable is dropped now and then by the freeze check
	swa_top u_dut (.CLK_SYS(clk), .RESET(rst), .CE(ce), .ISSUE_VALID(vld), .INSTR(ins),
		.SRC1_DATA(d1), .SRC2_DATA(d2), .SRC1_ADDR(a1), .SRC2_ADDR(a2), .WR_EN(we),
		.WR_ADDR(wa), .WR_DATA(wd), .OVF_EXC(ovf), .BAD_ZERO_FIELD(bad), .DONE(done));
	swa_rf_model u_rf (.clk(clk), .rd1_addr(a1), .rd2_addr(a2), .rd1_data(d1),
		.rd2_data(d2), .wr_en(we), .wr_addr(wa), .wr_data(wd));
	// ==========================================================
	// compare and verdict
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : report_and_stop
	function logic [31:0] rv(input logic [4:0] r);
		return (r == 5'h00) ? 32'h0 : u_rf.regs_r[r];
	endfunction : rv
	function logic [32:0] sx(input logic [31:0] v);
		return {v[31], v};
	endfunction : sx
	function logic [31:0] mk(input logic [5:0] f, input logic [4:0] s, t, d, z);
		return {6'h00, s, t, d, z, f};
	endfunction : mk
	// ==========================================================
	// one issue, expectation built from the operands held in the model
	task issue(input logic [31:0] w);
		logic [32:0] t;
		logic hit, trap;
		@(negedge clk) ins = w;
		vld = 1'b1;
		// operands read only now, after the previous write has landed in the model
		t = sx(rv(w[25:21])) + sx(rv(w[20:16]));
		hit = (w[31:26] == 6'h00) && (w[5:0] == 6'h20 || w[5:0] == 6'h21);
		trap = hit && w[5:0] == 6'h20 && t[32] != t[31];
		e_we = hit && !trap;
		e_ovf = trap;
		e_done = hit;
		e_wd = e_we ? t[31:0] : 32'h0;
		#1 chk(a1, w[25:21]);
		chk(a2, w[20:16]);
		@(negedge clk) vld = 1'b0;
		chk(done, e_done);
		chk(ovf, e_ovf);
		chk(we, e_we);
		chk(wd, e_wd);
		chk(wa, hit ? w[15:11] : 5'h00);
		chk(bad, hit && w[10:6] != 5'h00);
	endtask : issue
	// clock enable low for one edge: the last result must stand unchanged
	task freeze();
		ce = 1'b0;
		@(negedge clk) chk(we, e_we);
		chk(ovf, e_ovf);
		chk(wd, e_wd);
		chk(done, e_done);
		ce = 1'b1;
	endtask : freeze
	initial
	begin
		#200000 errors++;
		report_and_stop();
	end
	initial
	begin
		for (i = 0; i < 32; i++) u_rf.regs_r[i] = $random(seed);
		u_rf.regs_r[1] = 32'h7fffffff;
		u_rf.regs_r[2] = 32'h00000001;
		u_rf.regs_r[3] = 32'h80000000;
		u_rf.regs_r[4] = 32'hffffffff;
		repeat (4) @(negedge clk);
		rst = 1'b0;
		issue(mk(6'h20, 5'h01, 5'h02, 5'h05, 5'h00));
		issue(mk(6'h20, 5'h03, 5'h04, 5'h05, 5'h00));
		issue(mk(6'h21, 5'h01, 5'h02, 5'h06, 5'h00));
		issue(mk(6'h20, 5'h06, 5'h04, 5'h07, 5'h00));
		issue(mk(6'h22, 5'h01, 5'h02, 5'h08, 5'h00));
		issue(mk(6'h21, 5'h00, 5'h04, 5'h00, 5'h11));
		// reset in mid-run must clear a standing trap result
		issue(mk(6'h20, 5'h03, 5'h04, 5'h09, 5'h00));
		rst = 1'b1;
		@(negedge clk) chk(ovf, 1'b0);
		chk(we, 1'b0);
		chk(done, 1'b0);
		rst = 1'b0;
		$display("test corner done");
		// software keeps bits 10..6 clear in most random words
		for (i = 0; i < 80; i++)
		begin
			rw = $random(seed);
			if (i % 4 != 0) rw = mk(6'h20 | rw[0], rw[25:21], rw[20:16],
				rw[15:11], (i % 9 == 0) ? rw[10:6] : 5'h00);
			issue(rw);
			if (i % 16 == 5) freeze();
		end
		$display("test random done");
		report_and_stop();
	end
endmodule : tb
